// File: hw/esr_defs.svh
// What this block does
// - Sequential read starts like a current or random read; master acknowledges bytes.
// - On master acknowledge, the next byte shifts out with no further command.
// - Address counter increments by one after every byte output.
// - After the highest location the counter wraps to zero.
// - No acknowledge after a read byte releases data and returns to standby.
// - After a matching read select, output the byte at the address counter.
// - Byte address is sixteen bits; unused upper bits are ignored.
`ifndef ESR_DEFS_SVH
`define ESR_DEFS_SVH

`define ESR_ADDR_W 16
`define ESR_DATA_W 8
`define ESR_SEL_CODE 7'h50
`define ESR_ADDR_RST 16'h0000
`define ESR_FIFO_DEPTH 32
`define ESR_BIT_LAST 4'h7
`define ESR_BIT_SEL 4'h8
`define ESR_IDLE_BYTE 8'hff

`endif

// File: hw/esr_pkg.sv
`include "esr_defs.svh"

package esr_pkg;
   typedef logic [`ESR_ADDR_W-1:0] esr_addr_t;
   typedef logic [`ESR_DATA_W-1:0] esr_data_t;

   // Prefetched byte with the location it came from
   typedef struct packed {
      esr_addr_t addr;
      esr_data_t data;
   } esr_word_t;

   typedef enum logic [4:0] {
      ESR_IDLE = 5'h01,
      ESR_SEL = 5'h02,
      ESR_SELACK = 5'h04,
      ESR_TX = 5'h08,
      ESR_MACK = 5'h10
   } esr_state_t;
endpackage : esr_pkg

// File: hw/esr_fifo.sv
`include "esr_defs.svh"

module esr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = `ESR_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data = mem[rd_q[AW-1:0]];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + (AW+1)'(1);
         end
         if (pop) begin
            rd_q <= rd_q + (AW+1)'(1);
         end
      end
   end
endmodule : esr_fifo

// File: hw/esr_seq_read.sv
`include "esr_defs.svh"

module esr_seq_read #(
   parameter int MEM_BITS = `ESR_ADDR_W,
   parameter int FIFO_DEPTH = `ESR_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Two-wire pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Synchronous memory read port, data one cycle after enable
   output logic mem_rd_en,
   output esr_pkg::esr_addr_t mem_rd_addr,
   input wire esr_pkg::esr_data_t mem_rd_data,
   // Address load from the write side
   input wire logic addr_load_valid,
   input wire esr_pkg::esr_addr_t addr_load,
   // Status
   output esr_pkg::esr_addr_t addr_count,
   output logic reading
);
   import esr_pkg::*;

   localparam esr_addr_t ADDR_MASK = esr_addr_t'((33'h1 << MEM_BITS) - 33'h1);

   function automatic esr_addr_t next_addr(input esr_addr_t a);
      return (a + esr_addr_t'(1)) & ADDR_MASK;
   endfunction : next_addr

   function automatic logic sel_read(input esr_data_t b);
      return (b[7:1] == `ESR_SEL_CODE) && b[0];
   endfunction : sel_read

   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_q;
   logic sda_q;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   esr_state_t st_q;
   logic [3:0] bit_cnt_q;
   esr_data_t rx_q;
   esr_data_t tx_q;
   logic ack_q;
   logic sda_oe_q;
   logic reading_q;
   esr_addr_t addr_count_q;

   esr_addr_t fetch_addr_q;
   logic mem_rd_en_q;
   esr_addr_t mem_rd_addr_q;
   logic push_q;
   esr_addr_t push_addr_q;

   esr_word_t fifo_in;
   esr_word_t fifo_out;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic load;
   esr_data_t load_byte;
   logic nack_end;
   logic sel_reject;
   logic flush;
   logic issue;

   // Pins are asynchronous to ref_clk
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_q <= scl_sync_q[1];
         sda_q <= sda_sync_q[1];
      end
   end

   assign scl_s = scl_sync_q[1];
   assign sda_s = sda_sync_q[1];
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

   // Byte handed to the shifter at the end of an acknowledge slot
   assign load = scl_fall && ((st_q == ESR_SELACK) || ((st_q == ESR_MACK) && ack_q));
   // Prefetch keeps far ahead of the bit rate; an empty queue reads as released
   assign load_byte = fifo_out_valid ? fifo_out.data : `ESR_IDLE_BYTE;
   assign nack_end = (st_q == ESR_MACK) && scl_rise && sda_s;
   assign sel_reject = (st_q == ESR_SEL) && scl_fall && (bit_cnt_q == `ESR_BIT_SEL) && !sel_read(rx_q);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= ESR_IDLE;
         bit_cnt_q <= 4'h0;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         ack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (stop_det) begin
         st_q <= ESR_IDLE;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         st_q <= ESR_SEL;
         bit_cnt_q <= 4'h0;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (st_q)
            ESR_IDLE: begin
            end
            ESR_SEL: begin
               if (scl_rise) begin
                  rx_q <= {rx_q[6:0], sda_s};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall && bit_cnt_q == `ESR_BIT_SEL) begin
                  if (sel_read(rx_q)) begin
                     st_q <= ESR_SELACK;
                     sda_oe_q <= 1'b1;
                  end else begin
                     st_q <= ESR_IDLE;
                  end
               end
            end
            ESR_SELACK: begin
               if (load) begin
                  tx_q <= load_byte;
                  sda_oe_q <= ~load_byte[7];
                  bit_cnt_q <= 4'h0;
                  st_q <= ESR_TX;
               end
            end
            ESR_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_q == `ESR_BIT_LAST) begin
                     sda_oe_q <= 1'b0;
                     ack_q <= 1'b0;
                     st_q <= ESR_MACK;
                  end else begin
                     tx_q <= {tx_q[6:0], 1'b0};
                     sda_oe_q <= ~tx_q[6];
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            ESR_MACK: begin
               if (nack_end) begin
                  st_q <= ESR_IDLE;
               end else if (scl_rise) begin
                  ack_q <= 1'b1;
               end else if (load) begin
                  tx_q <= load_byte;
                  sda_oe_q <= ~load_byte[7];
                  bit_cnt_q <= 4'h0;
                  st_q <= ESR_TX;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reading_q <= 1'b0;
      end else begin
         reading_q <= (st_q == ESR_SELACK) || (st_q == ESR_TX) || (st_q == ESR_MACK);
      end
   end

   // Committed counter moves only on an address load or when a byte is really handed out
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_count_q <= `ESR_ADDR_RST;
      end else if (addr_load_valid) begin
         addr_count_q <= addr_load & ADDR_MASK;
      end else if (load && fifo_out_valid) begin
         addr_count_q <= next_addr(fifo_out.addr);
      end
   end

   // Speculative fetches are dropped whenever the stream may break
   assign flush = start_det | stop_det | nack_end | sel_reject | addr_load_valid;
   assign issue = fifo_in_ready & ~mem_rd_en_q & ~push_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fetch_addr_q <= `ESR_ADDR_RST;
         mem_rd_en_q <= 1'b0;
         mem_rd_addr_q <= `ESR_ADDR_RST;
         push_q <= 1'b0;
         push_addr_q <= `ESR_ADDR_RST;
      end else if (flush) begin
         fetch_addr_q <= addr_load_valid ? (addr_load & ADDR_MASK) : addr_count_q;
         mem_rd_en_q <= 1'b0;
         push_q <= 1'b0;
      end else begin
         mem_rd_en_q <= issue;
         push_q <= mem_rd_en_q;
         push_addr_q <= mem_rd_addr_q;
         if (issue) begin
            mem_rd_addr_q <= fetch_addr_q;
            fetch_addr_q <= next_addr(fetch_addr_q);
         end
      end
   end

   assign fifo_in = '{addr: push_addr_q, data: mem_rd_data};

   esr_fifo #(
      .WIDTH($bits(esr_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst(rst),
      .flush(flush),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(load),
      .out_data(fifo_out)
   );

   assign sda_o = 1'b0;
   assign sda_oe = sda_oe_q;
   assign mem_rd_en = mem_rd_en_q;
   assign mem_rd_addr = mem_rd_addr_q;
   assign addr_count = addr_count_q;
   assign reading = reading_q;

   property p_sel_ack;
      @(posedge ref_clk) disable iff (rst)
      (st_q == ESR_SEL && scl_fall && bit_cnt_q == `ESR_BIT_SEL && sel_read(rx_q) && !start_det && !stop_det)
         |=> (st_q == ESR_SELACK) && sda_oe;
   endproperty
   a_sel_ack: assert property (p_sel_ack) else $error("read select not acknowledged");

   property p_ack_continues;
      @(posedge ref_clk) disable iff (rst)
      (st_q == ESR_MACK && ack_q && scl_fall && !start_det && !stop_det) |=> st_q == ESR_TX && bit_cnt_q == 4'h0;
   endproperty
   a_ack_continues: assert property (p_ack_continues) else $error("no next byte after ack");

   property p_inc;
      @(posedge ref_clk) disable iff (rst)
      (load && fifo_out_valid && !addr_load_valid) |=> addr_count_q == next_addr($past(fifo_out.addr));
   endproperty
   a_inc: assert property (p_inc) else $error("counter not incremented");

   property p_wrap;
      @(posedge ref_clk) disable iff (rst)
      (load && fifo_out_valid && !addr_load_valid && fifo_out.addr == ADDR_MASK) |=> addr_count_q == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_nack_idle;
      @(posedge ref_clk) disable iff (rst)
      (nack_end && !stop_det && !start_det) |=> (st_q == ESR_IDLE) && !sda_oe ##1 !reading;
   endproperty
   a_nack_idle: assert property (p_nack_idle) else $error("no standby after nack");

   property p_first_byte;
      @(posedge ref_clk) disable iff (rst)
      (st_q == ESR_SELACK && load && fifo_out_valid) |-> fifo_out.addr == addr_count_q;
   endproperty
   a_first_byte: assert property (p_first_byte) else $error("byte not from counter address");

   property p_mask;
      @(posedge ref_clk) disable iff (rst)
      ((addr_count_q & ~ADDR_MASK) == 16'h0000) && ((mem_rd_addr_q & ~ADDR_MASK) == 16'h0000);
   endproperty
   a_mask: assert property (p_mask) else $error("unused address bits set");

   property p_msb_first;
      @(posedge ref_clk) disable iff (rst)
      (st_q == ESR_TX && scl_fall && bit_cnt_q != `ESR_BIT_LAST && !start_det && !stop_det)
         |=> sda_oe == !$past(tx_q[6]) && bit_cnt_q == $past(bit_cnt_q) + 4'h1;
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("bit order broken");

   property p_ack_slot;
      @(posedge ref_clk) disable iff (rst)
      $rose(st_q == ESR_MACK) |-> !sda_oe && $past(bit_cnt_q) == `ESR_BIT_LAST;
   endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("ack slot not after eight bits");

   property p_stop;
      @(posedge ref_clk) disable iff (rst)
      stop_det |=> st_q == ESR_IDLE && !sda_oe;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not honoured");
endmodule : esr_seq_read

// File: dv/esr_master_model.sv
module esr_master_model (
   // Clock
   input wire logic ref_clk,
   // Bus wires, open drain
   input wire logic sda,
   output logic scl,
   output logic sda_low,
   // Byte taken off the bus
   output logic rx_valid,
   output esr_pkg::esr_data_t rx_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   import esr_pkg::*;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      rx_valid = 1'b0;
      rx_byte = '0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // Low 14 cycles, high 8: above the minimum widths after the pin synchronisers
   task automatic clk_bit(input logic b, output logic r);
      sda_low <= !b;
      tick(7);
      scl <= 1'b1;
      tick(8);
      r = sda;
      scl <= 1'b0;
      tick(7);
   endtask : clk_bit

   task automatic bus_start;
      tick(8);
      sda_low <= 1'b1;
      tick(8);
      scl <= 1'b0;
      tick(7);
   endtask : bus_start

   task automatic bus_stop;
      sda_low <= 1'b1;
      tick(7);
      scl <= 1'b1;
      tick(8);
      sda_low <= 1'b0;
      tick(14);
   endtask : bus_stop

   task automatic send_byte(input esr_data_t b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(b[i], r);
      end
      clk_bit(1'b1, r);
      ack = !r;
   endtask : send_byte

   // Released line during the slot after the last byte ends the read
   task automatic recv_byte(input logic last);
      esr_data_t d;
      logic r;
      d = '0;
      for (int i = 0; i < 8; i++) begin
         clk_bit(1'b1, r);
         d = {d[6:0], r};
      end
      rx_byte <= d;
      rx_valid <= 1'b1;
      tick(1);
      rx_valid <= 1'b0;
      clk_bit(last, r);
   endtask : recv_byte
endmodule : esr_master_model

// File: dv/esr_seq_read_test.sv
`include "esr_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end

module esr_seq_read_test;
   timeunit 1ns;
   timeprecision 1ns;
   import esr_pkg::*;

   // Small array so the wrap is reached quickly
   localparam int MEM_BITS = 4;
   localparam esr_addr_t MASK = 16'h000f;

   logic ref_clk, rst, addr_load_valid, scl, sda_low, sda, sda_o, sda_oe, mem_rd_en, reading, rx_valid;
   esr_addr_t addr_load, addr_count, mem_rd_addr, ra;
   esr_data_t mem_rd_data, rx_byte, exp_v;
   esr_data_t exp_q[$];
   int n_errors = 0;
   int checked = 0;

   assign sda = !((sda_oe && !sda_o) || sda_low);

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   function automatic esr_data_t pat(input esr_addr_t a);
      return (a[7:0] * 8'h1d) ^ 8'h5a;
   endfunction : pat

   // Data valid only in the cycle after the strobe, scrambled otherwise
   always @(posedge ref_clk) begin
      if (mem_rd_en) mem_rd_data <= pat(mem_rd_addr & MASK);
      else mem_rd_data <= ~mem_rd_data;
   end

   esr_master_model master (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
      .rx_valid(rx_valid), .rx_byte(rx_byte));

   esr_seq_read #(.MEM_BITS(MEM_BITS), .FIFO_DEPTH(32)) dut (.ref_clk(ref_clk), .rst(rst), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
      .mem_rd_data(mem_rd_data), .addr_load_valid(addr_load_valid), .addr_load(addr_load),
      .addr_count(addr_count), .reading(reading));

   always @(posedge ref_clk) begin
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("mismatch rx_byte expected none seen %h", rx_byte);
         end else begin
            exp_v = exp_q.pop_front();
            `CHK("rx_byte", exp_v, rx_byte)
         end
      end
   end

   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   task automatic load(input esr_addr_t a);
      addr_load <= a;
      addr_load_valid <= 1'b1;
      @(posedge ref_clk);
      addr_load_valid <= 1'b0;
      repeat (10) @(posedge ref_clk);
   endtask : load

   task automatic seq_rd(input esr_addr_t a, input int n);
      logic ack;
      esr_addr_t e;
      e = a & MASK;
      master.bus_start();
      master.send_byte({`ESR_SEL_CODE, 1'b1}, ack);
      `CHK("select_ack", 1'b1, ack)
      `CHK("reading_on", 1'b1, reading)
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(pat(e));
         e = (e + 16'h0001) & MASK;
         master.recv_byte(i == n - 1);
      end
      // Standby must follow the released slot, before any STOP
      `CHK("reading", 1'b0, reading)
      `CHK("sda_oe", 1'b0, sda_oe)
      master.bus_stop();
      `CHK("addr_count", e, addr_count)
      `CHK("queue_empty", 1'b1, exp_q.size() == 0)
   endtask : seq_rd

   initial begin
      logic ack;
      int n;
      rst = 1'b1;
      addr_load_valid = 1'b0;
      addr_load = '0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (10) @(posedge ref_clk);
      void'($urandom(78335));
      seq_rd(16'h0000, 1);
      $display("test current_read done");
      seq_rd(16'h0001, 3);
      $display("test seq_from_current done");
      load(16'hfffd);
      seq_rd(16'hfffd, 5);
      $display("test wrap done");
      for (int i = 0; i < 3; i++) begin
         master.bus_start();
         master.send_byte(i == 0 ? {`ESR_SEL_CODE, 1'b0} : (i == 1 ? 8'hc1 : 8'ha3), ack);
         `CHK("refused_ack", 1'b0, ack)
         `CHK("refused_reading", 1'b0, reading)
         master.bus_stop();
      end
      seq_rd(16'h0002, 1);
      $display("test refused_select done");
      for (int k = 0; k < 3; k++) begin
         ra = esr_addr_t'($urandom());
         n = int'($urandom_range(4, 1));
         load(ra);
         seq_rd(ra, n);
      end
      $display("test random_reads done");
      // Reset in mid-run, bus idle: counter back to zero, pins released
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      `CHK("rst_addr_count", 16'h0000, addr_count)
      `CHK("rst_reading", 1'b0, reading)
      `CHK("rst_sda_oe", 1'b0, sda_oe)
      $display("test mid_reset done");
      repeat (400) @(posedge ref_clk);
      seq_rd(16'h0000, 40);
      $display("test long_read done");
      test_done();
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      n_errors++;
      $display("mismatch watchdog expected done seen hang");
      test_done();
   end
endmodule : esr_seq_read_test
